// ---- hdl/ecm_consts.svh ----
// Register offsets, field positions and reset values of the misc control registers
`ifndef ECM_CONSTS_SVH
`define ECM_CONSTS_SVH

`define ECM_OFS_BUS_ERR_CTRL    8'h14
`define ECM_OFS_IRQ_VEC_CTRL    8'h18
`define ECM_OFS_TRACE_EN        8'h1C
`define ECM_OFS_DEBUG_EN        8'h20
`define ECM_OFS_DBG_STATUS      8'h24

`define ECM_BIT_MEM_EXC_DIS     0
`define ECM_BIT_BUS_ERR_TEST    1
`define ECM_BIT_ALT_VEC_EN      0
`define ECM_BIT_TRACE_EN        0
`define ECM_BIT_DBG_EN          0
`define ECM_BIT_PIN_CFG_LO      1
`define ECM_BIT_PULLUP_EN       3

`define ECM_RST_BUS_ERR_CTRL    2'h0
`define ECM_RST_ALT_VEC_EN      1'h1
`define ECM_RST_TRACE_EN        1'h0
`define ECM_RST_DEBUG_EN        4'h0

`endif

// ---- hdl/ecm_pkg.sv ----
// Types shared by the misc control register block
package ecm_pkg;

    // Debug pin hand-over selection
    typedef enum logic [1:0] {
        ECM_PINS_FOUR_WIRE  = 2'h0,
        ECM_PINS_TWO_TRACE  = 2'h1,
        ECM_PINS_TWO_WIRE   = 2'h2,
        ECM_PINS_RESERVED   = 2'h3
    } ecm_pin_cfg_t;

    // Debug enable register content
    typedef struct packed {
        logic         pullup_en;
        ecm_pin_cfg_t pin_cfg;
        logic         dbg_en;
    } ecm_dbg_cfg_t;

    // Per-pin debug hand-over: clock, mode select, data in, data out
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic tdo;
    } ecm_dbg_pins_t;

    // Classic Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } ecm_wb_req_t;

endpackage

// ---- hdl/ecm_pin_sync.sv ----
// Three-stage pin synchroniser with two-stage agreement filter
`timescale 1ns/100ps
`default_nettype none

module ecm_pin_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    output logic      level_o
);

    logic s1_q;
    logic s2_q;
    logic s3_q;

    // Stage one feeds only stage two, so metastability stays contained
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Level changes only once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_o <= RESET_VAL;
        end else if (s2_q == s3_q) begin
            level_o <= s3_q;
        end
    end

endmodule

`default_nettype wire

// ---- hdl/ecm_misc_regs.sv ----
// Misc embedded-controller control registers with classic Wishbone slave
//
// Overview of operation
// - Bit 0 of error control, when 1, suppresses processor memory-error exceptions; resets 0.
// - Alternate-vector enable, bit 0 of interrupt control, gives dedicated vectors; resets 1.
// - Trace enable bit forces trace pins to trace functions; 0 disables; resets 0.
// - Pull-up enable bit turns on debug pull-ups while debug enabled and reset pin high.
// - Pull-ups apply only to pins the pin configuration field selects.
// - Pin configuration 0 hands all four test pins to debug on high test-reset.
// - Pin configuration 1 hands clock, mode select and data-out; data-in stays GPIO.
// - Pin configuration 2 hands clock and mode select only; data pins stay GPIO.
// - Debug enable 1 lets a high test-reset enable the port, mode by two-wire select.
// - Debug enable 0 ignores test-reset and keeps all test pins in normal function.
// - System reset returns every register and all logic to defaults.
// - Register reads and writes still complete while the block is asleep.
`timescale 1ns/100ps
`default_nettype none
`include "ecm_consts.svh"

module ecm_misc_regs #(
    parameter int ADDR_W = 8
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // Classic Wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [ADDR_W-1:0]     wb_adr_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic [31:0]                wb_dat_o,
    output logic                       wb_ack_o,
    output logic                       wb_err_o,
    // Power control sleep request, test-reset pin and two-wire select
    input  wire logic                  sleep_req_i,
    input  wire logic                  test_rst_pin_i,
    input  wire logic                  two_wire_sel_i,
    // Controls to the rest of the subsystem
    output logic                       mem_exc_disable_o,
    output logic                       alt_vector_enable_o,
    output logic                       trace_port_enable_o,
    output logic                       debug_port_active_o,
    output logic                       debug_two_wire_o,
    output ecm_pkg::ecm_dbg_pins_t     debug_pin_sel_o,
    output ecm_pkg::ecm_dbg_pins_t     debug_pullup_o
);
    import ecm_pkg::*;

    // Elaboration check: the status word at the top offset needs six address bits
    if (ADDR_W < 6 || ADDR_W > 8) begin : g_bad_addr_w
        $error("ADDR_W must lie between 6 and 8");
    end

    //------------------------------------------------------------------
    // Registers
    //------------------------------------------------------------------
    logic [1:0]    bus_err_ctrl_q;
    logic          alt_vec_en_q;
    logic          trace_en_q;
    ecm_dbg_cfg_t  dbg_cfg_q;
    logic          ack_q;
    logic          err_q;
    logic [31:0]   rdata_q;
    logic          test_rst_lvl;
    ecm_dbg_pins_t pin_sel_d;

    //------------------------------------------------------------------
    // Bus decode
    //------------------------------------------------------------------

    // Word offset compare, used for both write and read decode
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (8'(a) & 8'hFC) == ofs;
    endfunction

    logic req;
    logic wr;
    logic mapped;
    // New request only when no answer is in flight; sleep is not consulted
    assign req    = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
    assign wr     = req && wb_we_i && wb_sel_i[0];
    assign mapped = hit(wb_adr_i, `ECM_OFS_BUS_ERR_CTRL) || hit(wb_adr_i, `ECM_OFS_IRQ_VEC_CTRL)
                 || hit(wb_adr_i, `ECM_OFS_TRACE_EN) || hit(wb_adr_i, `ECM_OFS_DEBUG_EN)
                 || hit(wb_adr_i, `ECM_OFS_DBG_STATUS);

    // One-cycle answer; unmapped addresses get err instead of ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            ack_q <= req && mapped;
            err_q <= req && !mapped;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;

    //------------------------------------------------------------------
    // Write side: every field only in byte lane 0
    //------------------------------------------------------------------

    // Error control: memory-exception disable and a spare test bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_err_ctrl_q <= `ECM_RST_BUS_ERR_CTRL;
        end else if (wr && hit(wb_adr_i, `ECM_OFS_BUS_ERR_CTRL)) begin
            bus_err_ctrl_q <= wb_dat_i[1:0];
        end
    end

    // Alternate vector enable, on after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alt_vec_en_q <= `ECM_RST_ALT_VEC_EN;
        end else if (wr && hit(wb_adr_i, `ECM_OFS_IRQ_VEC_CTRL)) begin
            alt_vec_en_q <= wb_dat_i[`ECM_BIT_ALT_VEC_EN];
        end
    end

    // Trace port enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trace_en_q <= `ECM_RST_TRACE_EN;
        end else if (wr && hit(wb_adr_i, `ECM_OFS_TRACE_EN)) begin
            trace_en_q <= wb_dat_i[`ECM_BIT_TRACE_EN];
        end
    end

    // Debug configuration; reserved code 3 is stored but hands over nothing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dbg_cfg_q <= `ECM_RST_DEBUG_EN;
        end else if (wr && hit(wb_adr_i, `ECM_OFS_DEBUG_EN)) begin
            dbg_cfg_q <= wb_dat_i[3:0];
        end
    end

    //------------------------------------------------------------------
    // Read side
    //------------------------------------------------------------------

    // Read data registered with the ack; reserved bits return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (req) begin
            rdata_q <= 32'h0000_0000;
            if (hit(wb_adr_i, `ECM_OFS_BUS_ERR_CTRL)) begin
                rdata_q[1:0] <= bus_err_ctrl_q;
            end else if (hit(wb_adr_i, `ECM_OFS_IRQ_VEC_CTRL)) begin
                rdata_q[0] <= alt_vec_en_q;
            end else if (hit(wb_adr_i, `ECM_OFS_TRACE_EN)) begin
                rdata_q[0] <= trace_en_q;
            end else if (hit(wb_adr_i, `ECM_OFS_DEBUG_EN)) begin
                rdata_q[3:0] <= dbg_cfg_q;
            end else if (hit(wb_adr_i, `ECM_OFS_DBG_STATUS)) begin
                rdata_q[5:0] <= {sleep_req_i, test_rst_lvl, debug_port_active_o, pin_sel_d[3:1]};
            end
        end
    end

    assign wb_dat_o = rdata_q;

    //------------------------------------------------------------------
    // Debug pin hand-over
    //------------------------------------------------------------------

    // Test-reset arrives from a pin, so it is filtered into this domain
    ecm_pin_sync #(
        .RESET_VAL (1'b0)
    ) u_test_rst_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (test_rst_pin_i),
        .level_o (test_rst_lvl)
    );

    // Pin selection by configuration field
    always_comb begin
        pin_sel_d = '0;
        unique case (dbg_cfg_q.pin_cfg)
            ECM_PINS_FOUR_WIRE: pin_sel_d = 4'b1111;
            ECM_PINS_TWO_TRACE: pin_sel_d = 4'b1101;
            ECM_PINS_TWO_WIRE:  pin_sel_d = 4'b1100;
            ECM_PINS_RESERVED:  pin_sel_d = 4'b0000;
        endcase
    end

    logic dbg_active_q;
    // Pin is ignored entirely while debug is disabled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dbg_active_q <= 1'b0;
        end else begin
            dbg_active_q <= dbg_cfg_q.dbg_en && test_rst_lvl;
        end
    end

    // Outputs registered so they stay glitch free toward the pad mux
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            debug_pin_sel_o <= '0;
            debug_pullup_o  <= '0;
        end else begin
            debug_pin_sel_o <= (dbg_cfg_q.dbg_en && test_rst_lvl) ? pin_sel_d : '0;
            debug_pullup_o  <= (dbg_cfg_q.dbg_en && test_rst_lvl && dbg_cfg_q.pullup_en)
                             ? pin_sel_d : '0;
        end
    end

    assign debug_port_active_o = dbg_active_q;
    assign debug_two_wire_o    = dbg_active_q && two_wire_sel_i;
    assign mem_exc_disable_o   = bus_err_ctrl_q[`ECM_BIT_MEM_EXC_DIS];
    assign alt_vector_enable_o = alt_vec_en_q;
    assign trace_port_enable_o = trace_en_q;

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    sequence s_dbg_cond;
        dbg_cfg_q.dbg_en && test_rst_lvl;
    endsequence

    property p_mem_exc;
        @(posedge clk_i) disable iff (rst_i)
        wr && hit(wb_adr_i, `ECM_OFS_BUS_ERR_CTRL) |=> mem_exc_disable_o == $past(wb_dat_i[0]);
    endproperty
    a_mem_exc: assert property (p_mem_exc) else $error("exception disable not written");

    property p_alt_reset;
        @(posedge clk_i) $fell(rst_i) |-> alt_vector_enable_o && !trace_port_enable_o;
    endproperty
    a_alt_reset: assert property (p_alt_reset) else $error("bad vector or trace reset");

    property p_trace;
        @(posedge clk_i) disable iff (rst_i)
        wr && hit(wb_adr_i, `ECM_OFS_TRACE_EN) |=> trace_port_enable_o == $past(wb_dat_i[0]);
    endproperty
    a_trace: assert property (p_trace) else $error("trace enable not written");

    property p_pullup;
        @(posedge clk_i) disable iff (rst_i)
        debug_pullup_o != 4'b0000 |-> debug_port_active_o && (debug_pullup_o == debug_pin_sel_o);
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up outside debug pins");

    property p_cfg0;
        @(posedge clk_i) disable iff (rst_i)
        s_dbg_cond and (dbg_cfg_q.pin_cfg == ECM_PINS_FOUR_WIRE) |=> debug_pin_sel_o == 4'b1111;
    endproperty
    a_cfg0: assert property (p_cfg0) else $error("four-wire hand-over wrong");

    property p_cfg1;
        @(posedge clk_i) disable iff (rst_i)
        s_dbg_cond and (dbg_cfg_q.pin_cfg == ECM_PINS_TWO_TRACE) |=> debug_pin_sel_o == 4'b1101;
    endproperty
    a_cfg1: assert property (p_cfg1) else $error("two-wire trace hand-over wrong");

    property p_cfg2;
        @(posedge clk_i) disable iff (rst_i)
        s_dbg_cond and (dbg_cfg_q.pin_cfg == ECM_PINS_TWO_WIRE) |=> debug_pin_sel_o == 4'b1100;
    endproperty
    a_cfg2: assert property (p_cfg2) else $error("two-wire hand-over wrong");

    property p_dis;
        @(posedge clk_i) disable iff (rst_i)
        !dbg_cfg_q.dbg_en [*2] |-> debug_pin_sel_o == 4'b0000 && !debug_port_active_o;
    endproperty
    a_dis: assert property (p_dis) else $error("debug active while disabled");

    property p_sleep_ack;
        @(posedge clk_i) disable iff (rst_i)
        req && sleep_req_i |=> wb_ack_o || wb_err_o;
    endproperty
    a_sleep_ack: assert property (p_sleep_ack) else $error("access lost in sleep");

    property p_rsvd;
        @(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && hit(wb_adr_i, `ECM_OFS_DEBUG_EN) |=> wb_dat_o[31:4] == 28'h0000000;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");

    // Control bits move only on their own write; a stray decode would show here
    property p_alt_write;
        @(posedge clk_i) disable iff (rst_i)
        wr && hit(wb_adr_i, `ECM_OFS_IRQ_VEC_CTRL)
        |=> alt_vector_enable_o == $past(wb_dat_i[0]);
    endproperty
    a_alt_write: assert property (p_alt_write) else $error("vector enable not written");

    property p_mem_hold;
        @(posedge clk_i) disable iff (rst_i)
        !(wr && hit(wb_adr_i, `ECM_OFS_BUS_ERR_CTRL)) |=> $stable(mem_exc_disable_o);
    endproperty
    a_mem_hold: assert property (p_mem_hold) else $error("exception disable drifted");

    property p_trace_hold;
        @(posedge clk_i) disable iff (rst_i)
        !(wr && hit(wb_adr_i, `ECM_OFS_TRACE_EN)) |=> $stable(trace_port_enable_o);
    endproperty
    a_trace_hold: assert property (p_trace_hold) else $error("trace enable drifted");

    property p_rsvd_irq;
        @(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && hit(wb_adr_i, `ECM_OFS_IRQ_VEC_CTRL)
        |=> wb_dat_o[31:1] == 31'h0000_0000;
    endproperty
    a_rsvd_irq: assert property (p_rsvd_irq) else $error("vector reserved bits nonzero");

    property p_rst_defaults;
        @(posedge clk_i) $fell(rst_i)
        |-> !mem_exc_disable_o && !debug_port_active_o && debug_pin_sel_o == 4'h0
            && debug_pullup_o == 4'h0 && !wb_ack_o && !wb_err_o;
    endproperty
    a_rst_defaults: assert property (p_rst_defaults) else $error("state left after reset");

    // Port follows enable and synced pin one edge later
    property p_active;
        @(posedge clk_i) disable iff (rst_i)
        s_dbg_cond |=> debug_port_active_o;
    endproperty
    a_active: assert property (p_active) else $error("debug port not enabled");

    property p_pin_low;
        @(posedge clk_i) disable iff (rst_i)
        !test_rst_lvl |=> !debug_port_active_o && debug_pin_sel_o == 4'h0;
    endproperty
    a_pin_low: assert property (p_pin_low) else $error("hand-over without test-reset");

    property p_off;
        @(posedge clk_i) disable iff (rst_i)
        !dbg_cfg_q.dbg_en |=> !debug_port_active_o && debug_pullup_o == 4'h0;
    endproperty
    a_off: assert property (p_off) else $error("pull-ups while disabled");

    property p_pullup_on;
        @(posedge clk_i) disable iff (rst_i)
        s_dbg_cond and (dbg_cfg_q.pullup_en && dbg_cfg_q.pin_cfg != ECM_PINS_RESERVED)
        |=> debug_pullup_o != 4'h0 && debug_pullup_o == debug_pin_sel_o;
    endproperty
    a_pullup_on: assert property (p_pullup_on) else $error("pull-ups missing on debug pins");

endmodule

`default_nettype wire

// ---- dv/ecm_misc_regs_tb.sv ----
// Self-checking testbench for the misc control register block
`timescale 1ns/100ps
`default_nettype none
`include "ecm_consts.svh"

module ecm_misc_regs_tb;
    import ecm_pkg::*;

    logic                   clk_i;
    logic                   rst_i;
    logic                   wb_cyc_i;
    logic                   wb_stb_i;
    logic                   wb_we_i;
    logic [3:0]             wb_sel_i;
    logic [7:0]             wb_adr_i;
    logic [31:0]            wb_dat_i;
    logic [31:0]            wb_dat_o;
    logic                   wb_ack_o;
    logic                   wb_err_o;
    logic                   sleep_req_i;
    logic                   test_rst_pin_i;
    logic                   two_wire_sel_i;
    logic                   mem_exc_disable_o;
    logic                   alt_vector_enable_o;
    logic                   trace_port_enable_o;
    logic                   debug_port_active_o;
    logic                   debug_two_wire_o;
    ecm_dbg_pins_t          debug_pin_sel_o;
    ecm_dbg_pins_t          debug_pullup_o;
    int                     fail_count  = 0;
    int                     checks_done = 0;
    logic [33:0]            notes[$];
    logic [33:0]            note;
    logic [31:0]            sh  [4];
    logic [7:0]             ofs [4] = '{`ECM_OFS_BUS_ERR_CTRL, `ECM_OFS_IRQ_VEC_CTRL,
                                        `ECM_OFS_TRACE_EN, `ECM_OFS_DEBUG_EN};
    logic [31:0]            msk [4] = '{32'h3, 32'h1, 32'h1, 32'hF};
    logic [31:0]            dflt[4] = '{32'h0, 32'h1, 32'h0, 32'h0};

    ecm_misc_regs u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .sleep_req_i(sleep_req_i), .test_rst_pin_i(test_rst_pin_i),
        .two_wire_sel_i(two_wire_sel_i), .mem_exc_disable_o(mem_exc_disable_o),
        .alt_vector_enable_o(alt_vector_enable_o), .trace_port_enable_o(trace_port_enable_o),
        .debug_port_active_o(debug_port_active_o), .debug_two_wire_o(debug_two_wire_o),
        .debug_pin_sel_o(debug_pin_sel_o), .debug_pullup_o(debug_pullup_o));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (fail_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Hand-over mask per pin configuration, order {clock, mode, data in, data out}
    function automatic logic [3:0] pmask(input logic [1:0] c);
        case (c)
            2'h0:    return 4'hF;
            2'h1:    return 4'hD;
            2'h2:    return 4'hC;
            default: return 4'h0;
        endcase
    endfunction

    // One classic cycle; the answer note is queued before the request goes out
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      input logic [3:0] sel, input logic [31:0] exp, input logic err);
        notes.push_back({err, ~we & ~err, exp});
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input int i, input logic [31:0] d);
        logic [31:0] v;
        v = d;
        // Software never programs the reserved pin code
        if (i == 3 && v[2:1] == 2'h3) v[2] = 1'b0;
        wb(1'b1, ofs[i], v, 4'hF, 32'h0, 1'b0);
        sh[i] = v & msk[i];
    endtask

    task automatic rd_all();
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, ofs[i], 32'h0, 4'hF, sh[i], 1'b0);
        end
    endtask

    // Looks between edges so that registered outputs have landed
    task automatic port_chk(input logic [3:0] s, input logic [3:0] p, input logic a,
                            input logic t);
        @(negedge clk_i);
        check(32'(debug_pin_sel_o), 32'(s));
        check(32'(debug_pullup_o), 32'(p));
        check(32'({debug_port_active_o, debug_two_wire_o}), 32'({a, t}));
        check(32'({mem_exc_disable_o, alt_vector_enable_o, trace_port_enable_o}),
              32'({sh[0][0], sh[1][0], sh[2][0]}));
        @(posedge clk_i);
    endtask

    task automatic reset_chk();
        sh = dflt;
        rd_all();
        port_chk(4'h0, 4'h0, 1'b0, 1'b0);
    endtask

    // ----------------------------------------------------------------
    // Processes
    // ----------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // Each answer takes the oldest note; an unasked answer is a mismatch
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) begin
            if (notes.size() == 0) begin
                fail_count++;
                $display("wrong value at %0t: answer with no request pending", $time);
            end else begin
                note = notes.pop_front();
                check(32'({wb_ack_o, wb_err_o}), 32'({~note[33], note[33]}));
                if (note[32]) check(wb_dat_o, note[31:0]);
            end
        end
    end

    // Generous cap: the whole sequence needs well under 4000 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        close_out();
    end

    initial begin
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_sel_i = 4'h0;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0;
        sleep_req_i = 1'b0;
        test_rst_pin_i = 1'b0;
        two_wire_sel_i = 1'b0;
        void'($urandom(23));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        reset_chk();
        // Ones, zeros, then random words; odd passes run while asleep
        for (int n = 0; n < 8; n++) begin
            sleep_req_i <= n[0];
            for (int i = 0; i < 4; i++) begin
                wr(i, (n == 0) ? 32'hFFFFFFFF : (n == 1) ? 32'h0 : $urandom);
            end
            rd_all();
            port_chk(4'h0, 4'h0, 1'b0, 1'b0);
        end
        sleep_req_i <= 1'b0;
        // Byte lane 0 off and an unmapped place must both leave state alone
        wb(1'b1, ofs[3], ~sh[3], 4'hE, 32'h0, 1'b0);
        wb(1'b1, 8'h30, 32'hFFFFFFFF, 4'hF, 32'h0, 1'b1);
        wb(1'b0, 8'h30, 32'h0, 4'hF, 32'h0, 1'b1);
        rd_all();
        // Enabled with pull-ups but test-reset low: nothing handed over
        wr(3, 32'h9);
        repeat (8) @(posedge clk_i);
        port_chk(4'h0, 4'h0, 1'b0, 1'b0);
        test_rst_pin_i <= 1'b1;
        for (int k = 0; k < 32; k++) begin
            logic [1:0] c;
            logic [3:0] pm;
            // Four-wire use picks code 0, two-wire use 1 or 2; code 3 is never sent
            c = k[4] ? (k[1] ? 2'h2 : 2'h1) : 2'h0;
            pm = pmask(c);
            two_wire_sel_i <= k[4];
            wr(3, $urandom & 32'hFFFFFFF0 | 32'({k[3], c, k[0]}));
            repeat (8) @(posedge clk_i);
            port_chk(k[0] ? pm : 4'h0, (k[0] & k[3]) ? pm : 4'h0,
                     k[0], k[0] & k[4]);
            // Status word: sleep, synced pin, active, clock/mode/data-in selection
            wb(1'b0, `ECM_OFS_DBG_STATUS, 32'h0, 4'hF,
               32'({2'h1, k[0], pm[3:1]}), 1'b0);
        end
        // Reset in mid-run with the pin still high
        wr(3, 32'hF);
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        reset_chk();
        close_out();
    end

endmodule
`default_nettype wire
